// ### pnadv_reg.v
// advertisement register, bits 15 to 5, for one switch port
// holds the abilities the port offers its link partner, plus the
// fixed and reserved bits of the upper part of the word
// assumes a one-cycle write strobe and whole-word write data from the
// management access path, both synchronous to core_clk_in
// assumes the negotiation engine samples the adv_*_out levels
// assumes bits 4 to 0 are held elsewhere; they read back as zero here
// writes are taken one per edge, back to back; the last one wins
// no write is refused: read-only bits simply drop their data
// bit 9 stores whatever is written; software should keep it at zero
// reset is asynchronous; every output shows its default image at once
//
// Summary of operation
// - bit 10 read/write, resets to 1, advertises pause ability.
// - bit 8 read/write, resets to 1, advertises 100 full duplex.
// - bit 7 read/write, resets to 1, advertises 100 half duplex.
// - bit 6 read/write, resets to 1, advertises 10 full duplex.
// - bit 5 read/write, resets to 1, advertises 10 half duplex.
// - bit 9 reserved read/write, resets to 0, no meaning.

`default_nettype none
`include "pnadv_consts.vh"

module pnadv_reg (
    // clock and reset
    input  wire        core_clk_in,
    input  wire        resetn_in,
    // write side, from the management access path
    input  wire        wr_en_in,
    input  wire [15:0] wr_data_in,
    // read image and advertised levels
    output reg  [15:0] rd_data_out,
    output reg         adv_pause_out,
    output reg         adv_100fd_out,
    output reg         adv_100hd_out,
    output reg         adv_10fd_out,
    output reg         adv_10hd_out
);

    // timing: a write lands in the stored bits at the strobe edge; the
    // read image and the ability levels follow one edge later, so that
    // every output comes straight from a flop and a read never sees a
    // half-settled word

    // bit positions of the stored fields in the 16-bit word
    localparam [3:0]  POS_PAUSE = `PNADV_BIT_PAUSE;
    localparam [3:0]  POS_RSVD9 = `PNADV_BIT_RSVD9;
    localparam [3:0]  POS_100FD = `PNADV_BIT_100FD;
    localparam [3:0]  POS_100HD = `PNADV_BIT_100HD;
    localparam [3:0]  POS_10FD  = `PNADV_BIT_10FD;
    localparam [3:0]  POS_10HD  = `PNADV_BIT_10HD;

    // number of speed and duplex bits, and each one's place in the group
    localparam integer ABIL_NUM  = 4;
    localparam integer IDX_100FD = 3;
    localparam integer IDX_100HD = 2;
    localparam integer IDX_10FD  = 1;
    localparam integer IDX_10HD  = 0;

    // reset values of the stored fields
    localparam [0:0]  RST_PAUSE = `PNADV_RST_PAUSE;
    localparam [0:0]  RST_RSVD9 = `PNADV_RST_RSVD9;
    localparam [3:0]  RST_ABIL  = `PNADV_RST_ABIL;

    // fixed read-only fields and the absent low bits
    localparam [2:0]  RO_TOP    = `PNADV_RO_TOP;
    localparam [1:0]  RO_MID    = `PNADV_RO_MID;
    localparam [4:0]  LOW_ZERO  = `PNADV_LOW_ZERO;

    // read image while reset is held, built from the same field values
    localparam [15:0] RD_RST    = {RO_TOP, RO_MID, RST_PAUSE,
                                   RST_RSVD9, RST_ABIL, LOW_ZERO};

    // write data split per stored field
    wire                wr_pause_w;
    wire                wr_rsvd9_w;
    wire [ABIL_NUM-1:0] wr_abil_w;

    // stored field values
    wire                pause_w;
    wire                rsvd9_w;
    wire [ABIL_NUM-1:0] abil_w;

    // next values of the registered outputs
    reg  [15:0]         rd_image_nxt;
    wire                adv_pause_nxt;
    wire                adv_100fd_nxt;
    wire                adv_100hd_nxt;
    wire                adv_10fd_nxt;
    wire                adv_10hd_nxt;

    // writable fields of the data word; read-only bits 15 to 11 and
    // the absent bits 4 to 0 are dropped here, so writes cannot move them
    assign wr_pause_w = wr_data_in[POS_PAUSE];
    assign wr_rsvd9_w = wr_data_in[POS_RSVD9];
    assign wr_abil_w  = wr_data_in[POS_100FD:POS_10HD];

    // pause ability bit
    pnadv_bit #(
        .RST_VAL (RST_PAUSE)
    ) u_pause (
        .core_clk_in (core_clk_in),
        .resetn_in   (resetn_in),
        .wr_en_in    (wr_en_in),
        .wr_data_in  (wr_pause_w),
        .bit_out     (pause_w)
    );

    // reserved bit 9: stored and readable, but advertises nothing
    pnadv_bit #(
        .RST_VAL (RST_RSVD9)
    ) u_rsvd9 (
        .core_clk_in (core_clk_in),
        .resetn_in   (resetn_in),
        .wr_en_in    (wr_en_in),
        .wr_data_in  (wr_rsvd9_w),
        .bit_out     (rsvd9_w)
    );

    // speed and duplex abilities; group bit g is word bit 5 + g,
    // so group bit 3 is 100 full and group bit 0 is 10 half
    genvar g;
    generate
        for (g = 0; g < ABIL_NUM; g = g + 1) begin : g_abil
            pnadv_bit #(
                .RST_VAL (RST_ABIL[g])
            ) u_ab (
                .core_clk_in (core_clk_in),
                .resetn_in   (resetn_in),
                .wr_en_in    (wr_en_in),
                .wr_data_in  (wr_abil_w[g]),
                .bit_out     (abil_w[g])
            );
        end
    endgenerate

    // assemble the read image field by field; the fixed fields come
    // from constants, so no write can reach them
    always @* begin
        rd_image_nxt            = 16'h0000;
        rd_image_nxt[15:13]     = RO_TOP;
        rd_image_nxt[12:11]     = RO_MID;
        rd_image_nxt[POS_PAUSE] = pause_w;
        rd_image_nxt[POS_RSVD9] = rsvd9_w;
        rd_image_nxt[POS_100FD] = abil_w[IDX_100FD];
        rd_image_nxt[POS_100HD] = abil_w[IDX_100HD];
        rd_image_nxt[POS_10FD]  = abil_w[IDX_10FD];
        rd_image_nxt[POS_10HD]  = abil_w[IDX_10HD];
        rd_image_nxt[4:0]       = LOW_ZERO;
    end

    // ability levels handed to the negotiation engine; the reserved
    // bit has no level of its own
    assign adv_pause_nxt = pause_w;
    assign adv_100fd_nxt = abil_w[IDX_100FD];
    assign adv_100hd_nxt = abil_w[IDX_100HD];
    assign adv_10fd_nxt  = abil_w[IDX_10FD];
    assign adv_10hd_nxt  = abil_w[IDX_10HD];

    // read image register
    // reset shows the default word, fixed bits included
    always @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rd_data_out <= RD_RST;
        end else begin
            rd_data_out <= rd_image_nxt;
        end
    end

    // pause level for the negotiation engine
    // reset leaves pause advertised
    always @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            adv_pause_out <= RST_PAUSE;
        end else begin
            adv_pause_out <= adv_pause_nxt;
        end
    end

    // 100 full-duplex level
    // reset leaves it advertised
    always @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            adv_100fd_out <= RST_ABIL[IDX_100FD];
        end else begin
            adv_100fd_out <= adv_100fd_nxt;
        end
    end

    // 100 half-duplex level
    // reset leaves it advertised
    always @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            adv_100hd_out <= RST_ABIL[IDX_100HD];
        end else begin
            adv_100hd_out <= adv_100hd_nxt;
        end
    end

    // 10 full-duplex level
    // reset leaves it advertised
    always @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            adv_10fd_out <= RST_ABIL[IDX_10FD];
        end else begin
            adv_10fd_out <= adv_10fd_nxt;
        end
    end

    // 10 half-duplex level
    // reset leaves it advertised
    always @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            adv_10hd_out <= RST_ABIL[IDX_10HD];
        end else begin
            adv_10hd_out <= adv_10hd_nxt;
        end
    end

endmodule // pnadv_reg
`default_nettype wire

// ### pnadv_consts.vh
// constants for the auto-negotiation advertisement register (upper bits)
// assumes inclusion by the register module; definitions only
`ifndef PNADV_CONSTS_VH
`define PNADV_CONSTS_VH
`define PNADV_BIT_PAUSE     4'hA
`define PNADV_BIT_RSVD9     4'h9
`define PNADV_BIT_100FD     4'h8
`define PNADV_BIT_100HD     4'h7
`define PNADV_BIT_10FD      4'h6
`define PNADV_BIT_10HD      4'h5
`define PNADV_RO_TOP        3'h0
`define PNADV_RO_MID        2'h1
`define PNADV_RST_PAUSE     1'h1
`define PNADV_RST_RSVD9     1'h0
`define PNADV_RST_ABIL      4'hF
`define PNADV_LOW_ZERO      5'h00
`endif

// ### pnadv_bit.v
// one read/write register bit with a constant reset value
// assumes a synchronous write strobe and an asynchronous low reset
`default_nettype none
module pnadv_bit #(
    parameter [0:0] RST_VAL = 1'h0
) (
    input  wire core_clk_in,
    input  wire resetn_in,
    input  wire wr_en_in,
    input  wire wr_data_in,
    output reg  bit_out
);
    // hold value, load on write
    always @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            bit_out <= RST_VAL;
        end else if (wr_en_in) begin
            bit_out <= wr_data_in;
        end
    end
endmodule // pnadv_bit
`default_nettype wire

// ### pnadv_checker.sv
// port checker for the advertisement register
// assumes a bind from the bench top
`default_nettype none
module pnadv_checker (
    input wire logic        core_clk_in,
    input wire logic        resetn_in,
    input wire logic        wr_en_in,
    input wire logic [15:0] wr_data_in,
    input wire logic [15:0] rd_data_out,
    input wire logic        adv_pause_out,
    input wire logic        adv_100fd_out,
    input wire logic        adv_100hd_out,
    input wire logic        adv_10fd_out,
    input wire logic        adv_10hd_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0]  w_r;
    logic [15:0] d1_r;
    logic [15:0] d2_r;
    // two-cycle copy of each write, cleared by reset
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            w_r  <= 2'h0;
            d1_r <= 16'h0000;
            d2_r <= 16'h0000;
        end else begin
            w_r  <= {w_r[0], wr_en_in};
            d1_r <= wr_data_in;
            d2_r <= d1_r;
        end
    end
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!resetn_in);
    chk_pause_adv: assert property (
        w_r[1] |-> adv_pause_out == d2_r[10])
        else $error("pause");
    chk_fd100_adv: assert property (
        w_r[1] |-> adv_100fd_out == d2_r[8])
        else $error("100 full");
    chk_hd100_adv: assert property (
        w_r[1] |-> adv_100hd_out == d2_r[7])
        else $error("100 half");
    chk_fd10_adv: assert property (
        w_r[1] |-> adv_10fd_out == d2_r[6])
        else $error("10 full");
    chk_hd10_adv: assert property (
        w_r[1] |-> adv_10hd_out == d2_r[5])
        else $error("10 half");
    chk_spare_bit: assert property (
        w_r[1] |-> rd_data_out[9] == d2_r[9])
        else $error("bit 9");
    chk_fixed_top: assert property (
        rd_data_out[15:11] == 5'h01)
        else $error("fixed bits");
    chk_hold_value: assert property (
        !w_r[1] |-> rd_data_out == $past(rd_data_out))
        else $error("read image moved without a write");
endmodule // pnadv_checker
`default_nettype wire

// ### pnadv_reg_tb_top.sv
// bench top: write sequences with expected read images
// assumes the register and checker are compiled first
`default_nettype none
module pnadv_reg_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk_in   = 1'h0;
    logic        resetn_in     = 1'h0;
    logic        wr_en_in      = 1'h0;
    logic [15:0] wr_data_in    = 16'h0000;
    logic [15:0] rd_data_out;
    logic        adv_pause_out;
    logic        adv_100fd_out;
    logic        adv_100hd_out;
    logic        adv_10fd_out;
    logic        adv_10hd_out;
    int          bad_count     = 0;
    int          checked       = 0;
    pnadv_reg pnadv_reg_inst (
        .core_clk_in   (core_clk_in),
        .resetn_in     (resetn_in),
        .wr_en_in      (wr_en_in),
        .wr_data_in    (wr_data_in),
        .rd_data_out   (rd_data_out),
        .adv_pause_out (adv_pause_out),
        .adv_100fd_out (adv_100fd_out),
        .adv_100hd_out (adv_100hd_out),
        .adv_10fd_out  (adv_10fd_out),
        .adv_10hd_out  (adv_10hd_out)
    );
    // 50 MHz clock
    initial forever #10 core_clk_in = ~core_clk_in;
    // raise the write strobe with data
    task automatic w(input logic [15:0] d);
        @(negedge core_clk_in) wr_en_in = 1'h1;
        wr_data_in = d;
    endtask
    // idle, then compare read image and ability levels
    task automatic c(input logic [15:0] e);
        logic [20:0] got;
        logic [20:0] want;
        @(negedge core_clk_in) wr_en_in = 1'h0;
        @(negedge core_clk_in) checked++;
        got  = {rd_data_out, adv_pause_out, adv_100fd_out, adv_100hd_out,
                adv_10fd_out, adv_10hd_out};
        want = {e, e[10], e[8:5]};
        if (got !== want) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, want);
        end
    endtask
    task automatic final_report;
        if (bad_count == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // reset, single-bit walk, back-to-back writes, second reset
    initial begin
        repeat (20) @(negedge core_clk_in);
        resetn_in = 1'h1;
        c(16'h0DE0);
        w(16'hFFFF);
        c(16'h0FE0);
        for (int i = 5; i < 11; i++) begin
            w(16'hF81F | (16'h0001 << i));
            c(16'h0800 | (16'h0001 << i));
        end
        w(16'h0000);
        w(16'h07E0);
        c(16'h0FE0);
        resetn_in = 1'h0;
        c(16'h0DE0);
        resetn_in = 1'h1;
        c(16'h0DE0);
        w(16'h0000);
        c(16'h0800);
        final_report();
    end
endmodule // pnadv_reg_tb_top
bind pnadv_reg pnadv_checker pnadv_checker_inst (
    .core_clk_in   (core_clk_in),
    .resetn_in     (resetn_in),
    .wr_en_in      (wr_en_in),
    .wr_data_in    (wr_data_in),
    .rd_data_out   (rd_data_out),
    .adv_pause_out (adv_pause_out),
    .adv_100fd_out (adv_100fd_out),
    .adv_100hd_out (adv_100hd_out),
    .adv_10fd_out  (adv_10fd_out),
    .adv_10hd_out  (adv_10hd_out)
);
`default_nettype wire
